// file: rtl/aacr_pkg.sv
`default_nettype none

package aacr_pkg;

   // Core clock rate
   localparam int CLK_MHZ = 200;

   // Bus address: 0xb0 for writes, 0xb1 for reads
   localparam logic [6:0] DEV_ADDR = 7'h58;

   // Register offsets
   localparam logic [7:0] ADDR_FUNC    = 8'h01;
   localparam logic [7:0] ADDR_ATTACK  = 8'h02;
   localparam logic [7:0] ADDR_RELEASE = 8'h03;
   localparam logic [7:0] ADDR_HOLD    = 8'h04;
   localparam logic [7:0] ADDR_GAIN    = 8'h05;
   localparam logic [7:0] ADDR_LIMIT   = 8'h06;
   localparam logic [7:0] ADDR_MAXGAIN = 8'h07;

   // Reset values, indexed by offset
   localparam logic [7:0] RST_VAL [1:7] = '{
      8'hc3, 8'h05, 8'h0b, 8'h00, 8'h06, 8'h3a, 8'hc2};

   // Bits that a host write may change; the rest hold their defaults
   localparam logic [7:0] WMASK [1:7] = '{
      8'h61, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'hff, 8'hf3};

   // Function control fields
   localparam int BIT_AMP_EN        = 6;
   localparam int BIT_SOFT_SHUTDOWN = 5;
   localparam int BIT_FAULT         = 3;
   localparam int BIT_THERMAL       = 2;
   localparam int BIT_NOISE_GATE_ENABLE         = 0;

   // Time fields (registers 2 to 5)
   localparam int TIME_HI = 5;

   // Limiter and noise gate fields
   localparam int LIM_DIS_BIT = 7;
   localparam int QGT_HI      = 6;
   localparam int QGT_LO      = 5;
   localparam int LIM_LVL_HI  = 4;

   // Max gain and compression fields
   localparam int MAXG_HI  = 7;
   localparam int MAXG_LO  = 4;
   localparam int RATIO_HI = 1;
   localparam logic [1:0] RATIO_ONE_TO_ONE = 2'h0;

   // Timing
   localparam int RETRY_PERIOD_NS    = 110000;
   localparam int RETRY_CYCLES       = RETRY_PERIOD_NS * CLK_MHZ / 1000;
   localparam int RETRY_ON_NS        = 1000;
   localparam int RETRY_ON_CYCLES    = RETRY_ON_NS * CLK_MHZ / 1000;
   localparam int RETRY_CNT_W        = 16;
   localparam int DEGLITCH_NS        = 1000;
   localparam int DEGLITCH_CYCLES    = DEGLITCH_NS * CLK_MHZ / 1000;
   localparam int ATTACK_STEP_NS     = 106700;
   localparam int ATTACK_STEP_CYCLES = ATTACK_STEP_NS * CLK_MHZ / 1000;
   localparam int RELEASE_STEP_US    = 13700;
   localparam int RELEASE_STEP_CYCLES = RELEASE_STEP_US * CLK_MHZ;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } aacr_wr_t;

   typedef struct packed {
      logic [20:0] attack_min_cycles;
      logic [27:0] release_min_cycles;
      logic [27:0] hold_min_cycles;
      logic        hold_enable;
      logic [5:0]  static_gain_db;
      logic [3:0]  max_gain;
      logic [1:0]  compression_ratio;
      logic        limiter_disable;
      logic [1:0]  quiet_gate_threshold;
      logic [4:0]  limiter_level;
   } aacr_agc_cfg_t;

   typedef enum logic [2:0] {
      LS_IDLE, LS_RX, LS_ACK, LS_TX, LS_MACK
   } aacr_link_st_t;

   typedef enum logic [1:0] {
      K_DEV, K_REG, K_DATA
   } aacr_kind_t;

endpackage

`default_nettype wire

// file: rtl/aacr_sync.sv
`default_nettype none

module aacr_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] meta_q;

   // Two-flop synchroniser
   always_ff @(posedge clk_in) begin
      meta_q <= d_in;
      q_out  <= meta_q;
   end

endmodule

`default_nettype wire

// file: rtl/aacr_top.sv
// How it works
// - On output short, pulse the stage on briefly every 110 us until clear.
// - Over-current flag stays set after recovery; only a software write, enable pin low or reset clears.
// - Over-current flag sets on short, clears only when software writes 0, the enable pin goes low or on reset.
// - Deglitched thermal shutdown sets a latched flag, cleared by writing 0.
// - Amplifier enable bit runs the stage, overridden while thermal shutdown.
// - Software shutdown bit 1 stops control, bias and oscillator.
// - Noise gate runs only if enabled and compression is not 1:1.
// - Attack field sets minimum time between decreases, 0.1067 ms per step.
// - Registers 1 to 7 reset to c3,05,0b,00,06,3a,c2.
// - Device answers bus address 0xb0 for writes, 0xb1 for reads.
// - Release field sets minimum time between increases, 0.0137 s per step.
// - Hold field sets decrease-to-increase time; zero disables hold.
// - Fixed gain field is two's complement dB, -28 to 30.
// - Enable pin low shuts everything and restores all defaults.
`default_nettype none

module aacr_top
   import aacr_pkg::*;
#(
   parameter int RETRY_CYCLES_P   = RETRY_CYCLES,
   parameter int ATTACK_STEP_P    = ATTACK_STEP_CYCLES,
   parameter int RELEASE_STEP_P   = RELEASE_STEP_CYCLES
) (
   input  wire logic    core_clk_in,
   input  wire logic    rst_n_in,
   input  wire logic    en_pin_in,
   input  wire logic    short_in,
   input  wire logic    thermal_in,
   input  wire logic    link_clk_in,
   input  wire logic    scl_in,
   input  wire logic    sda_in,
   output logic         sda_out,
   output logic         sda_oe_out,
   output logic         amp_stage_enable_out,
   output logic         bias_osc_enable_out,
   output logic         noise_gate_active_out,
   output logic         thermal_shutdown_out,
   output logic         fault_flag_out,
   output logic         thermal_flag_out,
   output aacr_agc_cfg_t agc_cfg_out
);

   // ---------------- Core domain inputs ----------------
   logic       en_s;
   logic       short_s;
   logic       thermal_s;
   logic       wr_tgl_s;
   logic       rd_tgl_s;
   logic       wr_tgl_q;
   logic       rd_tgl_q;
   aacr_wr_t   wr_q;
   logic [7:0] rd_addr_q;

   aacr_sync #(.W(5)) u_core_sync (
      .clk_in (core_clk_in),
      .d_in   ({en_pin_in, short_in, thermal_in, wr_tgl_q, rd_tgl_q}),
      .q_out  ({en_s, short_s, thermal_s, wr_tgl_s, rd_tgl_s})
   );

   // Pin low or reset puts every register back to default
   wire core_rst = !rst_n_in || !en_s;

   logic wr_p_q;
   logic rd_p_q;
   logic rd_ack_q;
   logic [7:0] rd_data_q;
   logic lrst_src_q;

   wire wr_fire = wr_tgl_s ^ wr_p_q;
   wire rd_fire = rd_tgl_s ^ rd_p_q;

   // Trackers follow the toggles through reset, so no stale write replays
   always_ff @(posedge core_clk_in) begin
      lrst_src_q <= core_rst;
      wr_p_q     <= wr_tgl_s;
      rd_p_q     <= rd_tgl_s;
   end

   // ---------------- Register file ----------------
   logic [7:0] reg_q    [1:7];
   logic [7:0] reg_view [1:7];
   logic       fault_q;
   logic       therm_q;

   for (genvar i = 1; i <= 7; i++) begin : g_reg
      wire wr_hit = wr_fire && (wr_q.addr == 8'(i));
      always_ff @(posedge core_clk_in) begin
         if (core_rst) begin
            reg_q[i] <= RST_VAL[i];
         end else if (wr_hit) begin
            reg_q[i] <= (wr_q.data & WMASK[i])
                      | (RST_VAL[i] & ~WMASK[i]);
         end
      end
      if (i == 1) begin : g_flags
         assign reg_view[i] = reg_q[i]
                            | (8'(fault_q) << BIT_FAULT)
                            | (8'(therm_q) << BIT_THERMAL);
      end else begin : g_plain
         assign reg_view[i] = reg_q[i];
      end
   end

   // Read answer; unmapped offsets read zero
   wire       rd_map = (rd_addr_q >= ADDR_FUNC) && (rd_addr_q <= ADDR_MAXGAIN);
   wire [7:0] rd_val = rd_map ? reg_view[rd_addr_q[2:0]] : 8'h00;

   always_ff @(posedge core_clk_in) begin
      if (core_rst) begin
         rd_ack_q  <= 1'b0;
         rd_data_q <= 8'h00;
      end else if (rd_fire) begin
         rd_ack_q  <= rd_tgl_s;
         rd_data_q <= rd_val;
      end
   end

   // ---------------- Field decode ----------------
   wire [7:0] func_r   = reg_q[ADDR_FUNC[2:0]];
   wire       amp_en   = func_r[BIT_AMP_EN];
   wire       soft_shutdown     = func_r[BIT_SOFT_SHUTDOWN];
   wire       noise_gate_enable = func_r[BIT_NOISE_GATE_ENABLE];
   wire [5:0] attack_step_count  = reg_q[ADDR_ATTACK[2:0]][TIME_HI:0];
   wire [5:0] release_step_count = reg_q[ADDR_RELEASE[2:0]][TIME_HI:0];
   wire [5:0] hold_step_count    = reg_q[ADDR_HOLD[2:0]][TIME_HI:0];
   wire [5:0] static_gain_db     = reg_q[ADDR_GAIN[2:0]][TIME_HI:0];
   wire [7:0] limit_r  = reg_q[ADDR_LIMIT[2:0]];
   wire [7:0] maxg_r   = reg_q[ADDR_MAXGAIN[2:0]];
   wire [1:0] ratio    = maxg_r[RATIO_HI:0];

   wire wr_func   = wr_fire && (wr_q.addr == ADDR_FUNC);
   wire fault_clr = wr_func && !wr_q.data[BIT_FAULT];
   wire therm_clr = wr_func && !wr_q.data[BIT_THERMAL];

   // ---------------- Thermal deglitch ----------------
   logic       therm_db_q;
   logic [7:0] therm_cnt_q;

   wire therm_diff = thermal_s != therm_db_q;
   wire therm_done = therm_diff
                  && (therm_cnt_q == 8'(DEGLITCH_CYCLES - 1));
   wire therm_set  = therm_done && thermal_s;

   always_ff @(posedge core_clk_in) begin
      if (core_rst) begin
         therm_db_q  <= 1'b0;
         therm_cnt_q <= 8'h00;
      end else if (therm_done) begin
         therm_db_q  <= thermal_s;
         therm_cnt_q <= 8'h00;
      end else if (therm_diff) begin
         therm_cnt_q <= therm_cnt_q + 8'h01;
      end else begin
         therm_cnt_q <= 8'h00;
      end
   end

   // Set wins over a clearing write in the same cycle
   always_ff @(posedge core_clk_in) begin
      if (core_rst) begin
         therm_q <= 1'b0;
         fault_q <= 1'b0;
      end else begin
         therm_q <= therm_set || (therm_q && !therm_clr);
         fault_q <= short_s || (fault_q && !fault_clr);
      end
   end

   // ---------------- Short-circuit auto-recovery ----------------
   logic                   short_mode_q;
   logic [RETRY_CNT_W-1:0] retry_cnt_q;

   wire retry_wrap = retry_cnt_q == RETRY_CNT_W'(RETRY_CYCLES_P - 1);
   wire retry_on   = retry_cnt_q < RETRY_CNT_W'(RETRY_ON_CYCLES);
   wire retry_last = retry_cnt_q == RETRY_CNT_W'(RETRY_ON_CYCLES - 1);

   always_ff @(posedge core_clk_in) begin
      if (core_rst) begin
         short_mode_q <= 1'b0;
         retry_cnt_q  <= '0;
      end else if (!short_mode_q) begin
         short_mode_q <= short_s;
         retry_cnt_q  <= RETRY_CNT_W'(RETRY_ON_CYCLES);
      end else begin
         retry_cnt_q  <= retry_wrap ? '0
                                    : retry_cnt_q + RETRY_CNT_W'(1);
         if (retry_last && !short_s) begin
            short_mode_q <= 1'b0;
         end
      end
   end

   // ---------------- Outputs ----------------
   wire amp_run  = amp_en && !soft_shutdown && !therm_db_q;
   wire stage_d  = amp_run && (!short_mode_q || retry_on);
   wire ng_d     = noise_gate_enable && !soft_shutdown
                && (ratio != RATIO_ONE_TO_ONE);

   aacr_agc_cfg_t cfg_d;
   always_comb begin
      cfg_d = '0;
      cfg_d.attack_min_cycles =
         21'(attack_step_count * ATTACK_STEP_P);
      cfg_d.release_min_cycles =
         28'(release_step_count * RELEASE_STEP_P);
      cfg_d.hold_min_cycles =
         28'(hold_step_count * RELEASE_STEP_P);
      cfg_d.hold_enable = hold_step_count != 6'h00;
      cfg_d.static_gain_db = static_gain_db;
      cfg_d.max_gain = maxg_r[MAXG_HI:MAXG_LO];
      cfg_d.compression_ratio = ratio;
      cfg_d.limiter_disable = limit_r[LIM_DIS_BIT];
      cfg_d.quiet_gate_threshold = limit_r[QGT_HI:QGT_LO];
      cfg_d.limiter_level = limit_r[LIM_LVL_HI:0];
   end

   always_ff @(posedge core_clk_in) begin
      if (core_rst) begin
         amp_stage_enable_out  <= 1'b0;
         bias_osc_enable_out   <= 1'b0;
         noise_gate_active_out <= 1'b0;
         thermal_shutdown_out  <= 1'b0;
         fault_flag_out        <= 1'b0;
         thermal_flag_out      <= 1'b0;
         agc_cfg_out           <= '0;
      end else begin
         amp_stage_enable_out  <= stage_d;
         bias_osc_enable_out   <= !soft_shutdown;
         noise_gate_active_out <= ng_d;
         thermal_shutdown_out  <= therm_db_q;
         fault_flag_out        <= fault_q;
         thermal_flag_out      <= therm_q;
         agc_cfg_out           <= cfg_d;
      end
   end

   // ---------------- Link domain: serial target ----------------
   logic lrst_n_s;
   logic scl_s;
   logic sda_s;
   logic rd_ack_s;

   aacr_sync #(.W(4)) u_link_sync (
      .clk_in (link_clk_in),
      .d_in   ({!lrst_src_q, scl_in, sda_in, rd_ack_q}),
      .q_out  ({lrst_n_s, scl_s, sda_s, rd_ack_s})
   );

   aacr_link_st_t st_q;
   aacr_kind_t    kind_q;
   logic          scl_p_q;
   logic          sda_p_q;
   logic [2:0]    bit_q;
   logic [7:0]    sh_q;
   logic          rw_q;
   logic          ack_hi_q;
   logic [7:0]    ptr_q;

   wire       scl_rise = scl_s && !scl_p_q;
   wire       scl_fall = !scl_s && scl_p_q;
   wire       bus_start = scl_s && scl_p_q && sda_p_q && !sda_s;
   wire       bus_stop  = scl_s && scl_p_q && !sda_p_q && sda_s;
   wire [7:0] rx_byte  = {sh_q[6:0], sda_s};
   wire       rd_ready = rd_ack_s == rd_tgl_q;
   wire [7:0] tx_byte  = rd_ready ? rd_data_q : 8'hff;
   wire       addr_hit = rx_byte[7:1] == DEV_ADDR;

   always_ff @(posedge link_clk_in) begin
      if (!lrst_n_s) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (!lrst_n_s) begin
         st_q       <= LS_IDLE;
         kind_q     <= K_DEV;
         bit_q      <= 3'h0;
         sh_q       <= 8'h00;
         rw_q       <= 1'b0;
         ack_hi_q   <= 1'b0;
         ptr_q      <= 8'h00;
         sda_oe_out <= 1'b0;
         sda_out    <= 1'b0;
         wr_tgl_q   <= 1'b0;
         wr_q       <= '0;
         rd_tgl_q   <= 1'b0;
         rd_addr_q  <= 8'h00;
      end else if (bus_start) begin
         st_q       <= LS_RX;
         kind_q     <= K_DEV;
         bit_q      <= 3'h0;
         ack_hi_q   <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (bus_stop) begin
         st_q       <= LS_IDLE;
         sda_oe_out <= 1'b0;
      end else begin
         case (st_q)
            LS_RX: begin
               if (scl_rise) begin
                  sh_q  <= rx_byte;
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     st_q     <= LS_ACK;
                     ack_hi_q <= 1'b0;
                     case (kind_q)
                        K_DEV: begin
                           if (!addr_hit) begin
                              st_q <= LS_IDLE;
                           end
                           rw_q <= rx_byte[0];
                           if (addr_hit && rx_byte[0]) begin
                              rd_tgl_q  <= !rd_tgl_q;
                              rd_addr_q <= ptr_q;
                           end
                        end
                        K_REG:   ptr_q <= rx_byte;
                        default: wr_q  <= '{addr: ptr_q, data: rx_byte};
                     endcase
                  end
               end
            end
            LS_ACK: begin
               if (scl_rise) begin
                  ack_hi_q <= 1'b1;
               end else if (scl_fall && !ack_hi_q) begin
                  sda_oe_out <= 1'b1;
               end else if (scl_fall) begin
                  ack_hi_q   <= 1'b0;
                  bit_q      <= 3'h0;
                  sda_oe_out <= 1'b0;
                  st_q       <= LS_RX;
                  if (kind_q == K_DATA) begin
                     wr_tgl_q <= !wr_tgl_q;
                     ptr_q    <= ptr_q + 8'h01;
                  end
                  if (kind_q == K_DEV && rw_q) begin
                     st_q       <= LS_TX;
                     sh_q       <= tx_byte;
                     sda_oe_out <= !tx_byte[7];
                  end else if (kind_q == K_DEV) begin
                     kind_q <= K_REG;
                  end else begin
                     kind_q <= K_DATA;
                  end
               end
            end
            LS_TX: begin
               if (scl_rise) begin
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     st_q     <= LS_MACK;
                     ack_hi_q <= 1'b0;
                  end
               end else if (scl_fall) begin
                  sh_q       <= {sh_q[6:0], 1'b0};
                  sda_oe_out <= !sh_q[6];
               end
            end
            LS_MACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     st_q <= LS_IDLE;
                  end else begin
                     ack_hi_q  <= 1'b1;
                     ptr_q     <= ptr_q + 8'h01;
                     rd_tgl_q  <= !rd_tgl_q;
                     rd_addr_q <= ptr_q + 8'h01;
                  end
               end else if (scl_fall && !ack_hi_q) begin
                  sda_oe_out <= 1'b0;
               end else if (scl_fall) begin
                  ack_hi_q   <= 1'b0;
                  bit_q      <= 3'h0;
                  st_q       <= LS_TX;
                  sh_q       <= tx_byte;
                  sda_oe_out <= !tx_byte[7];
               end
            end
            default: begin
               sda_oe_out <= 1'b0;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// file: verification/aacr_top_props.sv
`default_nettype none

module aacr_top_props
   import aacr_pkg::*;
#(
   parameter int ATTACK_STEP_P = ATTACK_STEP_CYCLES
) (
   input wire logic          core_clk_in,
   input wire logic          rst_n_in,
   input wire logic          en_pin_in,
   input wire logic          short_in,
   input wire logic          thermal_in,
   input wire logic          amp_stage_enable_out,
   input wire logic          bias_osc_enable_out,
   input wire logic          noise_gate_active_out,
   input wire logic          thermal_shutdown_out,
   input wire logic          fault_flag_out,
   input wire logic          thermal_flag_out,
   input wire aacr_agc_cfg_t agc_cfg_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // Saturating run lengths: hot input, stage on during a short
   logic [8:0] hot_q;
   logic [8:0] on_q;
   wire  [8:0] hot_d = thermal_in ? hot_q + {8'h00, ~&hot_q} : 9'h000;
   wire        on_c  = short_in && amp_stage_enable_out;
   wire  [8:0] on_d  = on_c ? on_q + {8'h00, ~&on_q} : 9'h000;

   always_ff @(posedge core_clk_in) begin
      hot_q <= hot_d;
      on_q  <= on_d;
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in || !en_pin_in);

   chk_gate_ratio:
   assert property (noise_gate_active_out |-> bias_osc_enable_out &&
      agc_cfg_out.compression_ratio != RATIO_ONE_TO_ONE)
      else $error("noise gate active without its conditions");
   chk_fault_cause:
   assert property ($rose(fault_flag_out) |-> $past(short_in, 2) ||
      $past(short_in, 3) || $past(short_in, 4))
      else $error("fault flag set with no short");
   chk_fault_sets:
   assert property (short_in [*4] |=> fault_flag_out)
      else $error("fault flag missing during short");
   chk_stage_short:
   assert property ($rose(fault_flag_out) |-> ##[0:1] !amp_stage_enable_out)
      else $error("stage kept on at short");
   chk_retry_on:
   assert property (on_q <= 9'h0d2)
      else $error("retry on window too long");
   chk_deglitch:
   assert property ($rose(thermal_shutdown_out) |-> hot_q >= 9'h0c3)
      else $error("thermal shutdown without deglitch");
   chk_thermal_flag:
   assert property ($rose(thermal_shutdown_out) |-> ##[0:1] thermal_flag_out)
      else $error("thermal flag not set");
   chk_stage_hot:
   assert property (thermal_shutdown_out [*2] |-> !amp_stage_enable_out)
      else $error("stage on while hot");
   chk_hold_zero:
   assert property (agc_cfg_out.hold_enable ==
      (agc_cfg_out.hold_min_cycles != 28'h0))
      else $error("hold enable wrong");
   chk_attack_step:
   assert property ($changed(agc_cfg_out.attack_min_cycles) |->
      agc_cfg_out.attack_min_cycles % ATTACK_STEP_P == 0 &&
      agc_cfg_out.attack_min_cycles <= 63 * ATTACK_STEP_P)
      else $error("attack time not a step multiple");

   cover property ($rose(fault_flag_out));
   cover property ($rose(thermal_flag_out));
   cover property ($fell(noise_gate_active_out));
endmodule

bind aacr_top aacr_top_props #(
   .ATTACK_STEP_P(ATTACK_STEP_P)
) u_props (
   .core_clk_in          (core_clk_in),
   .rst_n_in             (rst_n_in),
   .en_pin_in            (en_pin_in),
   .short_in             (short_in),
   .thermal_in           (thermal_in),
   .amp_stage_enable_out (amp_stage_enable_out),
   .bias_osc_enable_out  (bias_osc_enable_out),
   .noise_gate_active_out(noise_gate_active_out),
   .thermal_shutdown_out (thermal_shutdown_out),
   .fault_flag_out       (fault_flag_out),
   .thermal_flag_out     (thermal_flag_out),
   .agc_cfg_out          (agc_cfg_out)
);

`default_nettype wire

// file: verification/aacr_host_model.sv
`default_nettype none

module aacr_host_model (
   input  wire logic clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_low_out
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] ADDR_WR = 8'hb0;
   localparam logic [7:0] ADDR_RD = 8'hb1;
   int         nak = 0;
   logic [7:0] rdat [8];

   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end

   // Third of a bit, 350 ns
   task automatic hw();
      repeat (70) @(posedge clk_in);
      #1;
   endtask

   task automatic bit_x(input logic b, output logic r);
      sda_low_out = !b;
      hw();
      scl_out = 1'b1;
      hw();
      r = sda_in;
      scl_out = 1'b0;
      hw();
   endtask

   task automatic start_c();
      sda_low_out = 1'b0;
      hw();
      scl_out = 1'b1;
      hw();
      sda_low_out = 1'b1;
      hw();
      scl_out = 1'b0;
      hw();
   endtask

   task automatic fin();
      sda_low_out = 1'b1;
      hw();
      scl_out = 1'b1;
      hw();
      sda_low_out = 1'b0;
      hw();
   endtask

   task automatic put(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
      end
      bit_x(1'b1, r);
      if (r !== 1'b0) begin
         nak++;
      end
   endtask

   // Offsets handed in stay at 0x08 or below
   task automatic beg_wr(input logic [7:0] off);
      start_c();
      put(ADDR_WR);
      put(off);
   endtask

   task automatic rd(input logic [7:0] off, input int n);
      logic r;
      beg_wr(off);
      start_c();
      put(ADDR_RD);
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            rdat[k][i] = r;
         end
         bit_x(k == n - 1, r);
      end
      fin();
   endtask
endmodule

`default_nettype wire

// file: verification/tb_top.sv
`default_nettype none

module tb_top
   import aacr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int STEP_P  = 10;
   localparam int RETRY_P = 400;
   logic          clk     = 1'b0;
   logic          lclk    = 1'b0;
   logic          rst_n   = 1'b0;
   logic          en_pin  = 1'b1;
   logic          short_c = 1'b0;
   logic          hot     = 1'b0;
   int            failures = 0;
   int            compares = 0;
   wire logic     scl, low, sda_oe, sda, sdo;
   wire logic     stage, bias, gate, tsd, fault, tflag;
   wire aacr_agc_cfg_t cfg;

   assign sda = !low && (!sda_oe || sdo);

   initial forever #2.5 clk = ~clk;
   initial begin
      #1.3;
      forever #7.5 lclk = ~lclk;
   end

   aacr_top #(
      .RETRY_CYCLES_P(RETRY_P),
      .ATTACK_STEP_P (STEP_P),
      .RELEASE_STEP_P(STEP_P)
   ) dut (
      .core_clk_in          (clk),
      .rst_n_in             (rst_n),
      .en_pin_in            (en_pin),
      .short_in             (short_c),
      .thermal_in           (hot),
      .link_clk_in          (lclk),
      .scl_in               (scl),
      .sda_in               (sda),
      .sda_out              (sdo),
      .sda_oe_out           (sda_oe),
      .amp_stage_enable_out (stage),
      .bias_osc_enable_out  (bias),
      .noise_gate_active_out(gate),
      .thermal_shutdown_out (tsd),
      .fault_flag_out       (fault),
      .thermal_flag_out     (tflag),
      .agc_cfg_out          (cfg)
   );

   aacr_host_model host (
      .clk_in     (clk),
      .sda_in     (sda),
      .scl_out    (scl),
      .sda_low_out(low)
   );

   task automatic cmp_reg(input string n, input logic [7:0] e, g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cmp_val(input string n, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %0h seen %0h", n, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wreg(input logic [7:0] off, input logic [7:0] d);
      host.beg_wr(off);
      host.put(d);
      host.fin();
      cyc(10);
   endtask

   task automatic t_defaults();
      host.rd(8'h00, 8);
      cmp_reg("offset 0", 8'h00, host.rdat[0]);
      for (int i = 1; i < 8; i++) begin
         cmp_reg("reset value", RST_VAL[i], host.rdat[i]);
      end
      cmp_val("acks", 0, host.nak);
      cmp_val("attack", 5 * STEP_P, cfg.attack_min_cycles);
      cmp_val("release", 11 * STEP_P, cfg.release_min_cycles);
      cmp_val("hold on", 0, cfg.hold_enable);
      cmp_val("gain", 6, cfg.static_gain_db);
      cmp_reg("reg6 fields", 8'h3a, {cfg.limiter_disable,
         cfg.quiet_gate_threshold, cfg.limiter_level});
      cmp_val("bias", 1, bias);
      cmp_val("gate", 1, gate);
   endtask

   task automatic t_probe();
      host.start_c();
      host.put(8'ha0);
      host.fin();
      cmp_val("foreign address", 1, host.nak);
   endtask

   task automatic t_write_all();
      host.beg_wr(8'h01);
      for (int i = 1; i <= 8; i++) begin
         host.put(8'hff);
      end
      host.fin();
      host.rd(8'h01, 7);
      for (int i = 1; i < 8; i++) begin
         cmp_reg("written", RST_VAL[i] | WMASK[i], host.rdat[i - 1]);
      end
      cmp_val("bias off", 0, bias);
      cmp_val("gate off", 0, gate);
      cmp_val("attack max", 63 * STEP_P, cfg.attack_min_cycles);
      cmp_val("hold max", 63 * STEP_P, cfg.hold_min_cycles);
      cmp_val("hold on", 1, cfg.hold_enable);
      cmp_val("gain", 32'h3f, cfg.static_gain_db);
      cmp_reg("reg6 fields", 8'hff, {cfg.limiter_disable,
         cfg.quiet_gate_threshold, cfg.limiter_level});
      cmp_reg("reg7 fields", 8'hf3,
         {cfg.max_gain, 2'h0, cfg.compression_ratio});
   endtask

   task automatic t_enable();
      wreg(8'h01, 8'h41);
      cmp_val("bias on", 1, bias);
      cmp_val("stage on", 1, stage);
      cmp_val("gate on", 1, gate);
   endtask

   task automatic t_faults();
      int   t [4];
      int   k;
      logic p;
      k = 0;
      short_c = 1'b1;
      p = stage;
      for (int c = 0; c < 1200; c++) begin
         cyc(1);
         if (k < 4 && stage !== p) begin
            t[k] = c;
            k++;
         end
         p = stage;
      end
      cmp_val("retry period", RETRY_P, t[3] - t[1]);
      cmp_val("retry on", RETRY_ON_CYCLES, t[2] - t[1]);
      cmp_val("fault set", 1, fault);
      short_c = 1'b0;
      cyc(700);
      cmp_val("recovered", 1, stage);
      cmp_val("fault kept", 1, fault);
      hot = 1'b1;
      cyc(100);
      hot = 1'b0;
      cyc(300);
      cmp_val("glitch flag", 0, tflag);
      hot = 1'b1;
      cyc(300);
      cmp_val("shutdown", 1, tsd);
      cmp_val("hot flag", 1, tflag);
      cmp_val("stage hot", 0, stage);
      hot = 1'b0;
      cyc(300);
      cmp_val("stage cool", 1, stage);
      cmp_val("flag kept", 1, tflag);
   endtask

   task automatic t_clear();
      wreg(8'h01, 8'h01);
      cmp_val("fault clear", 0, fault);
      cmp_val("hot clear", 0, tflag);
      cmp_val("stage off", 0, stage);
      wreg(8'h07, 8'hf0);
      cmp_val("gate ratio", 0, gate);
   endtask

   task automatic t_enpin();
      en_pin = 1'b0;
      cyc(5);
      en_pin = 1'b1;
      cyc(10);
      cmp_val("attack back", 5 * STEP_P, cfg.attack_min_cycles);
      cmp_val("stage back", 1, stage);
      cmp_val("gate back", 1, gate);
   endtask

   task automatic tally_and_finish();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #470000;
      failures++;
      tally_and_finish();
   end

   initial begin
      cyc(4);
      rst_n = 1'b1;
      cyc(300);
      t_defaults();
      t_probe();
      t_write_all();
      t_enable();
      t_faults();
      t_clear();
      t_enpin();
      tally_and_finish();
   end
endmodule

`default_nettype wire
